// [dv/host_reader.sv]
// Host controller model that clocks serial results out of the port
`timescale 1ns/10ps
`default_nettype none
module host_reader (
    // Serial clock toward the device
    output logic        serial_clock,
    // Serial data pin level
    input  wire logic   serial_data
);
    // Clock stands low between frames
    initial serial_clock = 1'b0;

    // Two sync edges, then 16 bits; sampled on fall, or on rise if inverted
    task automatic read_word(input logic inv, output logic [15:0] word);
        word = 16'h0000;
        #7.3;
        for (int i = 0; i < 19; i++) begin
            #62.5 serial_clock = 1'b1;
            if (inv && i >= 3) word = {word[14:0], serial_data};
            #62.5 serial_clock = 1'b0;
            if (!inv && i >= 2 && i < 18) word = {word[14:0], serial_data};
        end
    endtask : read_word
endmodule : host_reader
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the converter output port configuration
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        sys_clk;
    logic        reset_n;
    logic        serial_clock_in;
    logic [15:0] result_data;
    logic        result_valid;
    logic        output_coding_select;
    logic        port_type_select;
    logic [2:0]  shared_pin_in;
    logic [15:0] data_bus_out;
    logic [15:0] data_bus_oe;
    logic        sdo;
    logic        sdo_oe;
    logic        sclk_out;
    logic        sclk_oe;
    logic        marker;
    logic        marker_oe;
    int          n_mismatch;
    int          check_count;

    adc_output_port_config dut (
        .sys_clk              (sys_clk),
        .reset_n              (reset_n),
        .serial_clock_in      (serial_clock_in),
        .result_data          (result_data),
        .result_valid         (result_valid),
        .output_coding_select (output_coding_select),
        .port_type_select     (port_type_select),
        .shared_pin_in        (shared_pin_in),
        .data_bus_out         (data_bus_out),
        .data_bus_oe          (data_bus_oe),
        .serial_result_out    (sdo),
        .serial_result_oe     (sdo_oe),
        .serial_clock_out     (sclk_out),
        .serial_clock_oe      (sclk_oe),
        .frame_marker_out     (marker),
        .frame_marker_oe      (marker_oe)
    );

    host_reader host (
        .serial_clock (serial_clock_in),
        .serial_data  (sdo)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Selects change only while no transfer runs
    task automatic set_mode(input logic coding, input logic port,
                            input logic [2:0] shared);
        @(negedge sys_clk);
        output_coding_select = coding;
        port_type_select     = port;
        shared_pin_in        = shared;
        repeat (4) @(negedge sys_clk);
    endtask : set_mode

    task automatic send(input logic [15:0] w);
        @(negedge sys_clk);
        result_data  = w;
        result_valid = 1'b1;
        @(negedge sys_clk);
        result_valid = 1'b0;
    endtask : send

    // Serial selects high on the shared pins must not disturb the bus
    task automatic test_parallel();
        logic [15:0] w;
        for (int c = 0; c < 2; c++) begin
            w = 16'hA5C3 ^ 16'(c * 16'h1111);
            set_mode(c[0], 1'b0, 3'h7);
            send(w);
            @(negedge sys_clk);
            check("parallel_bus", c[0] ? w : w ^ 16'h8000, data_bus_out);
            check("parallel_oe", 16'hFFFF, data_bus_oe);
        end
        $display("test_parallel done");
    endtask : test_parallel

    // All polarity and clock-invert combinations with the internal clock
    task automatic test_internal();
        logic [15:0] w;
        logic [15:0] got;
        for (int m = 0; m < 4; m++) begin
            w   = 16'h9E37 + 16'(m);
            got = 16'h0000;
            set_mode(m[0], 1'b1, {m[1], m[0], 1'b0});
            check("serial_bus_oe", 16'hFE0F, data_bus_oe);
            check("int_oe", 16'h0007, {13'h0, sdo_oe, sclk_oe, marker_oe});
            check("marker_idle", 16'(m[0]), 16'(marker));
            send(w);
            for (int k = 1; k <= 33; k++) begin
                @(negedge sys_clk);
                if (k % 2 == 1 && k < 32) got = {got[14:0], sdo};
                if (k == 1) check("clk_active", 16'(!m[1]), 16'(sclk_out));
                if (k == 2) check("clk_idle", 16'(m[1]), 16'(sclk_out));
                if (k == 1) check("marker_on", 16'(!m[0]), 16'(marker));
                if (k == 33) check("marker_off", 16'(m[0]), 16'(marker));
            end
            check("int_word", m[0] ? w : w ^ 16'h8000, got);
        end
        $display("test_internal done");
    endtask : test_internal

    // Host supplies the serial clock only within its frames
    task automatic test_external();
        logic [15:0] got;
        for (int c = 0; c < 4; c++) begin
            set_mode(c[0], 1'b1, {c[1], c[0], 1'b1});
            check("ext_oe", 16'h0005, {13'h0, sdo_oe, sclk_oe, marker_oe});
            send(16'h4B1D);
            repeat (2) @(negedge sys_clk);
            host.read_word(c[1], got);
            check("ext_word", c[0] ? 16'h4B1D : 16'hCB1D, got);
            check("ext_marker", 16'(c[0]), 16'(marker));
        end
        $display("test_external done");
    endtask : test_external

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        n_mismatch           = 0;
        check_count          = 0;
        reset_n              = 1'b0;
        result_data          = 16'h0000;
        result_valid         = 1'b0;
        output_coding_select = 1'b1;
        port_type_select     = 1'b0;
        shared_pin_in        = 3'h0;
        repeat (3) @(negedge sys_clk);
        check("reset_oe", 16'h000F, data_bus_oe);
        reset_n = 1'b1;
        $display("test_reset done");
        test_parallel();
        test_internal();
        test_external();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// [logic/adc_output_port_config.sv]
// Output port configuration: parallel bus or serial port of the converter
// Function
// (R1) Coding select high: straight binary output
// (R2) Coding select low: invert only MSB
// (R3) Port select low: drive full parallel bus
// (R4) Port select high: serial mode, pins reassigned
// (R5) Bus bits zero to three always outputs
// (R6) Parallel mode drives bit four on pin
// (R7) Internal clock: generate and drive serial clock
// (R8) External clock: data follows host serial clock
// (R9) Parallel mode drives bit five on pin
// (R10) Polarity select low: frame marker active high
// (R11) Polarity select high: frame marker active low
// (R12) Bit six pin inverts serial clock
// (R13) Bit eight pin shifts result MSB first
// (R14) Host keeps selects stable during transfers
`timescale 1ns/10ps
`default_nettype none
module adc_output_port_config (
    // Clocks and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        serial_clock_in,
    // Conversion result
    input  wire logic [15:0] result_data,
    input  wire logic        result_valid,
    // Select pins
    input  wire logic        output_coding_select,
    input  wire logic        port_type_select,
    input  wire logic [2:0]  shared_pin_in,
    // Data bus pins
    output logic      [15:0] data_bus_out,
    output logic      [15:0] data_bus_oe,
    // Serial port pins
    output logic             serial_result_out,
    output logic             serial_result_oe,
    output logic             serial_clock_out,
    output logic             serial_clock_oe,
    output logic             frame_marker_out,
    output logic             frame_marker_oe
);
    logic [4:0]  cfg_raw;
    logic [4:0]  cfg_meta;
    logic [4:0]  cfg_sync;
    logic        coding_sel;
    logic        serial;
    logic        clk_src;
    logic        polarity_sel;
    logic        invert_sel;
    logic [15:0] coded_word;
    logic        coded_msb;
    logic        start_int;
    logic        link_bit;

    logic [15:0] next_data_bus_out;
    logic [15:0] next_data_bus_oe;
    logic        next_serial_result_oe;
    logic        next_serial_clock_oe;
    logic        next_frame_marker_oe;

    logic [15:0] ext_word;
    logic        ext_toggle;
    logic [15:0] next_ext_word;
    logic        next_ext_toggle;

    adc_port_pkg::serial_state_t state;
    adc_port_pkg::serial_state_t next_state;
    logic [3:0]  half_count;
    logic [3:0]  next_half_count;
    logic        phase;
    logic        next_phase;
    logic [3:0]  bit_count;
    logic [3:0]  next_bit_count;
    logic [15:0] shift;
    logic [15:0] next_shift;
    logic        int_bit;
    logic        next_int_bit;
    logic        next_serial_clock_out;
    logic        next_frame_marker_out;
    logic        in_idle;
    logic        in_shift;

    // Pins are asynchronous: two flops before use
    assign cfg_raw = {shared_pin_in[2], shared_pin_in[1], shared_pin_in[0],
                      port_type_select, output_coding_select};

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_meta <= adc_port_pkg::CFG_RESET;
            cfg_sync <= adc_port_pkg::CFG_RESET;
        end else begin
            cfg_meta <= cfg_raw;
            cfg_sync <= cfg_meta;
        end
    end

    assign coding_sel   = cfg_sync[adc_port_pkg::CFG_CODING];
    assign serial       = cfg_sync[adc_port_pkg::CFG_PORT];
    assign clk_src      = cfg_sync[adc_port_pkg::CFG_CLK_SRC];
    assign polarity_sel = cfg_sync[adc_port_pkg::CFG_POLARITY];
    assign invert_sel   = cfg_sync[adc_port_pkg::CFG_INVERT];

    // MSB flipped only for two's complement
    assign coded_word = {result_data[15] ^ ~coding_sel, result_data[14:0]}; // R1 R2
    assign coded_msb  = coded_word[15];
    assign start_int  = result_valid && serial && !clk_src;
    assign in_idle    = (state == adc_port_pkg::ST_IDLE);
    assign in_shift   = (state == adc_port_pkg::ST_SHIFT);

    // Pin direction per mode
    always_comb begin
        next_data_bus_out = result_valid ? coded_word : data_bus_out;
        next_data_bus_oe  = serial ? adc_port_pkg::SERIAL_OE_MASK
                                   : adc_port_pkg::PARALLEL_OE_MASK; // R3 R4 R5 R6 R9
        next_serial_result_oe = serial; // R13
        next_serial_clock_oe  = serial && !clk_src; // R7 R8
        next_frame_marker_oe  = serial;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_bus_out     <= adc_port_pkg::WORD_RESET;
            data_bus_oe      <= adc_port_pkg::BUS_OE_RESET;
            serial_result_oe <= 1'b0;
            serial_clock_oe  <= 1'b0;
            frame_marker_oe  <= 1'b0;
        end else begin
            data_bus_out     <= next_data_bus_out;
            data_bus_oe      <= next_data_bus_oe;
            serial_result_oe <= next_serial_result_oe;
            serial_clock_oe  <= next_serial_clock_oe;
            frame_marker_oe  <= next_frame_marker_oe;
        end
    end

    // Hand word to the external clock domain
    always_comb begin
        next_ext_word   = ext_word;
        next_ext_toggle = ext_toggle;
        if (result_valid && serial && clk_src) begin
            next_ext_word   = coded_word; // R8
            next_ext_toggle = ~ext_toggle;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_word   <= adc_port_pkg::WORD_RESET;
            ext_toggle <= 1'b0;
        end else begin
            ext_word   <= next_ext_word;
            ext_toggle <= next_ext_toggle;
        end
    end

    serial_link_shifter u_link (
        .link_clk    (serial_clock_in),
        .reset_n     (reset_n),
        .load_toggle (ext_toggle),
        .load_word   (ext_word),
        .invert_pin  (shared_pin_in[2]),
        .link_bit    (link_bit)
    );

    // Internal serial clock and frame generator
    always_comb begin
        next_state            = state;
        next_half_count       = half_count;
        next_phase            = phase;
        next_bit_count        = bit_count;
        next_shift            = shift;
        next_int_bit          = int_bit;
        next_serial_clock_out = serial_clock_out;
        next_frame_marker_out = frame_marker_out;
        unique case (state)
            adc_port_pkg::ST_IDLE: begin
                next_serial_clock_out = invert_sel; // R12
                next_frame_marker_out = polarity_sel;
                if (start_int) begin
                    next_state            = adc_port_pkg::ST_SHIFT;
                    next_shift            = {coded_word[14:0], 1'b0};
                    next_int_bit          = coded_word[15]; // R13
                    next_half_count       = 4'h0;
                    next_phase            = 1'b0;
                    next_bit_count        = 4'h0;
                    next_frame_marker_out = ~polarity_sel; // R10 R11
                end
            end
            adc_port_pkg::ST_SHIFT: begin
                if (half_count != adc_port_pkg::SCLK_HALF_LAST) begin
                    next_half_count = half_count + 4'h1;
                end else begin
                    next_half_count = 4'h0;
                    next_phase      = ~phase;
                    if (!phase) begin
                        next_serial_clock_out = ~invert_sel; // R7 R12
                    end else begin
                        next_serial_clock_out = invert_sel;
                        if (bit_count == adc_port_pkg::LAST_BIT) begin
                            next_state            = adc_port_pkg::ST_IDLE;
                            next_frame_marker_out = polarity_sel;
                        end else begin
                            next_int_bit   = shift[15]; // R13
                            next_shift     = {shift[14:0], 1'b0};
                            next_bit_count = bit_count + 4'h1;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state            <= adc_port_pkg::ST_IDLE;
            half_count       <= 4'h0;
            phase            <= 1'b0;
            bit_count        <= 4'h0;
            shift            <= adc_port_pkg::WORD_RESET;
            int_bit          <= 1'b0;
            serial_clock_out <= 1'b0;
            frame_marker_out <= 1'b0;
        end else begin
            state            <= next_state;
            half_count       <= next_half_count;
            phase            <= next_phase;
            bit_count        <= next_bit_count;
            shift            <= next_shift;
            int_bit          <= next_int_bit;
            serial_clock_out <= next_serial_clock_out;
            frame_marker_out <= next_frame_marker_out;
        end
    end

    // Serial data source follows the clock source
    assign serial_result_out = clk_src ? link_bit : int_bit; // R8 R13

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_start;
        in_idle && start_int;
    endsequence

    sequence s_first_bit;
        (int_bit == $past(coded_msb)) ##1 (serial_clock_out != invert_sel);
    endsequence

    sequence s_frame_end;
        in_shift ##1 (in_idle && frame_marker_out == polarity_sel);
    endsequence

    property p_msb_first;
        s_start |=> s_first_bit;
    endproperty

    a_straight_binary: assert property ( // R1
        result_valid && coding_sel |=> data_bus_out == $past(result_data))
        else $error("Straight binary result altered");
    a_twos_complement: assert property ( // R2
        result_valid && !coding_sel |=>
        data_bus_out == ($past(result_data) ^ adc_port_pkg::MSB_MASK))
        else $error("Two's complement MSB not inverted");
    a_parallel_drive: assert property ( // R3
        !serial |=> data_bus_oe == adc_port_pkg::PARALLEL_OE_MASK
                    && !serial_result_oe && !frame_marker_oe)
        else $error("Parallel bus not fully driven");
    a_serial_reassign: assert property ( // R4
        serial |=> data_bus_oe[6:4] == 3'h0 && serial_result_oe
                   && frame_marker_oe)
        else $error("Serial pins not reassigned");
    a_low_bits_out: assert property ( // R5
        data_bus_oe[3:0] == 4'hF)
        else $error("Low bus bits not driven");
    a_shared_bits_out: assert property ( // R6 R9
        !serial ##1 !serial |=>
        data_bus_oe[adc_port_pkg::BIT_CLOCK_SOURCE]
        && data_bus_oe[adc_port_pkg::BIT_FRAME_POLARITY])
        else $error("Bits four or five not driven");
    a_internal_clock: assert property ( // R7
        serial && !clk_src |=> serial_clock_oe)
        else $error("Internal serial clock not driven");
    a_external_clock: assert property ( // R8
        serial && clk_src |=> !serial_clock_oe)
        else $error("Serial clock driven in external mode");
    a_frame_polarity: assert property ( // R10 R11
        in_shift && $past(in_shift) |-> frame_marker_out == !polarity_sel)
        else $error("Frame marker level wrong");
    a_clock_idle_level: assert property ( // R12
        in_idle |=> serial_clock_out == $past(invert_sel))
        else $error("Serial clock idle level wrong");
    a_msb_first: assert property (p_msb_first) // R13
        else $error("First serial bit is not the MSB");
    // Sixteen bits of two cycles each, then marker back to rest
    a_frame_length: assert property ( // R10 R11 R13
        s_start |-> ##32 s_frame_end)
        else $error("Serial frame length wrong");
    a_bit_change_edge: assert property ( // R7 R13
        in_shift && $changed(int_bit) |-> serial_clock_out == invert_sel)
        else $error("Serial bit changed on active clock edge");
endmodule : adc_output_port_config
`default_nettype wire

// [logic/adc_port_pkg.sv]
// Shared constants and types for the converter output port
package adc_port_pkg;
    localparam int RESULT_WIDTH = 16;
    localparam int LOW_OUT_BITS = 4;

    // Bus pin positions reused by the serial port
    localparam int BIT_CLOCK_SOURCE   = 4;
    localparam int BIT_FRAME_POLARITY = 5;
    localparam int BIT_CLOCK_INVERT   = 6;
    localparam int BIT_SERIAL_OUT     = 8;

    // Positions in the synchronised select vector
    localparam int CFG_CODING   = 0;
    localparam int CFG_PORT     = 1;
    localparam int CFG_CLK_SRC  = 2;
    localparam int CFG_POLARITY = 3;
    localparam int CFG_INVERT   = 4;
    localparam int CFG_WIDTH    = 5;

    // Output enables per mode; pins 4..8 released in serial mode
    localparam logic [15:0] PARALLEL_OE_MASK = 16'hFFFF;
    localparam logic [15:0] SERIAL_OE_MASK   = 16'hFE0F;
    localparam logic [15:0] MSB_MASK         = 16'h8000;

    // Values after reset
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    localparam logic [15:0] BUS_OE_RESET = 16'h000F;
    localparam logic [4:0]  CFG_RESET    = 5'h00;

    // Internal serial clock timing
    localparam int SYS_CLK_PERIOD_PS  = 25000;
    localparam int SCLK_MIN_PERIOD_PS = 40000;
    localparam int SCLK_HALF_RAW =
        (SCLK_MIN_PERIOD_PS / 2 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;
    localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYCLES - 1);
    localparam logic [3:0] LAST_BIT       = 4'(RESULT_WIDTH - 1);

    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } serial_state_t;
endpackage : adc_port_pkg

// [logic/serial_link_shifter.sv]
// Serial result shifter clocked by the external serial clock
`timescale 1ns/10ps
`default_nettype none
module serial_link_shifter (
    // Link clock and reset
    input  wire logic        link_clk,
    input  wire logic        reset_n,
    // Word handed over from the system domain
    input  wire logic        load_toggle,
    input  wire logic [15:0] load_word,
    // Clock invert pin, raw
    input  wire logic        invert_pin,
    // Serial bit toward the pin
    output logic             link_bit
);
    logic        tog_meta;
    logic        tog_sync;
    logic        tog_seen;
    logic        inv_meta;
    logic        inv_sync;
    logic [15:0] shift;
    logic        rise_bit;
    logic        fall_bit;
    logic        next_tog_seen;
    logic [15:0] next_shift;
    logic        next_rise_bit;

    // Word stays stable in the sender until the next result
    always_comb begin
        next_tog_seen = tog_sync;
        next_shift    = {shift[14:0], 1'b0};
        next_rise_bit = shift[15];
        if (tog_sync != tog_seen) begin
            next_shift    = {load_word[14:0], 1'b0};
            next_rise_bit = load_word[15];
        end
    end

    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
            inv_meta <= 1'b0;
            inv_sync <= 1'b0;
            shift    <= adc_port_pkg::WORD_RESET;
            rise_bit <= 1'b0;
        end else begin
            tog_meta <= load_toggle;
            tog_sync <= tog_meta;
            tog_seen <= next_tog_seen;
            inv_meta <= invert_pin;
            inv_sync <= inv_meta;
            shift    <= next_shift;
            rise_bit <= next_rise_bit;
        end
    end

    // Falling-edge copy for the inverted clock
    always_ff @(negedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            fall_bit <= 1'b0;
        end else begin
            fall_bit <= rise_bit;
        end
    end

    always_comb begin
        link_bit = inv_sync ? fall_bit : rise_bit; // R12
    end
endmodule : serial_link_shifter
`default_nettype wire
